// ===== verilog/mfs_supervisor.sv
`timescale 1ns/10ps
// Motor protection fault supervisor
module mfs_supervisor #(
  parameter int OVERCUR_CYC = mfs_pkg::OVERCUR_CYC,
  parameter int TICK_CYC    = mfs_pkg::TICK_CYC,
  parameter int FLASH_CYC   = mfs_pkg::FLASH_HALF_CYC
) (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  // Sensing and start state
  input  wire mfs_pkg::mfs_sense_t i_sense,
  input  wire mfs_pkg::mfs_start_t i_start,
  // Settings
  input  wire logic [15:0]        i_motor_nom,
  input  wire logic [15:0]        i_rated,
  input  wire logic [15:0]        i_ramp_ms,
  input  wire logic [23:0]        i_therm_limit,
  input  wire logic               i_auto_reset_en,
  // Reset sources
  input  wire logic               i_reset_key,
  input  wire logic               i_din_reset,
  input  wire logic               i_auto_reset,
  // Thermal state save and restore
  input  wire logic               i_power_fail,
  input  wire logic               i_restore_vld,
  input  wire logic [23:0]        i_restore_val,
  output logic                    o_save_vld,
  output logic [23:0]             o_save_val,
  // Status
  output logic [6:0]              o_fault_code,
  output logic                    o_starter_en,
  output mfs_pkg::mfs_led_t       o_led
);

  // Elaboration check on timing parameters
  if (OVERCUR_CYC < 1 || TICK_CYC < 1 || FLASH_CYC < 1) begin : g_bad_param
    $error("mfs_supervisor: bad timing parameters");
  end

  //----------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT  = 3'b001,
    ST_RUN   = 3'b010,
    ST_FAULT = 3'b100
  } mfs_mode_t;

  typedef struct packed {
    mfs_mode_t   mode;
    logic [6:0]  code;
    logic [23:0] therm;
    logic [31:0] oc_cnt;
    logic [31:0] tick;
    logic [15:0] ramp_ms;
    logic [1:0]  seq_pos;
    logic [2:0]  sync_d;
    logic        saved;
    logic        save_vld;
  } mfs_state_t;

  mfs_state_t st_ff, nxt_st;

  //----------------------------------------------------------------------
  // Comparisons
  //----------------------------------------------------------------------
  logic [15:0] cur_max;
  logic [31:0] short_lim, stall_lim, oc_lim, cur_pct;
  logic        over_nom, det_short, det_stall, det_oc_lvl, det_timeout;
  logic        det_overload, det_phseq;
  logic [2:0]  sync_fall;
  logic [6:0]  det_code;
  logic        clear_req;

  // Largest phase current
  always_comb begin
    cur_max = i_sense.cur_a;
    if (i_sense.cur_b > cur_max) begin
      cur_max = i_sense.cur_b;
    end
    if (i_sense.cur_c > cur_max) begin
      cur_max = i_sense.cur_c;
    end
  end

  // Thresholds
  assign cur_pct   = 32'(cur_max) * 32'd100;
  assign short_lim = 32'(i_rated) * 32'(mfs_pkg::SHORT_PCT);
  assign stall_lim = 32'(i_motor_nom) * 32'(mfs_pkg::STALL_MULT);
  assign oc_lim    = 32'(i_motor_nom) * 32'(mfs_pkg::OVERCUR_MULT);
  assign over_nom  = cur_max > i_motor_nom;

  // Fault detectors
  assign det_short   = !i_start.run_cmd && i_start.stopped
                       && (cur_pct > short_lim);
  assign det_stall   = !i_start.full_volt && !i_start.stopped
                       && (32'(cur_max) > stall_lim);
  assign det_oc_lvl  = i_start.full_volt && (32'(cur_max) > oc_lim);
  assign det_timeout = i_start.cur_limit_mode && i_start.ramping
                       && (st_ff.ramp_ms >= i_ramp_ms);
  assign det_overload = st_ff.therm >= i_therm_limit;
  assign sync_fall   = st_ff.sync_d & ~i_sense.sync;

  // Phase order: falls must go A, B, C in turn
  always_comb begin
    det_phseq = 1'b0;
    case (sync_fall)
      3'b000:  det_phseq = 1'b0;
      3'b001:  det_phseq = st_ff.seq_pos != 2'd0;
      3'b010:  det_phseq = st_ff.seq_pos != 2'd1;
      3'b100:  det_phseq = st_ff.seq_pos != 2'd2;
      default: det_phseq = 1'b1;
    endcase
  end

  // Priority of simultaneous detections
  always_comb begin
    if (det_short) begin
      det_code = mfs_pkg::FC_SHORT;
    end else if (det_stall) begin
      det_code = mfs_pkg::FC_STALL;
    end else if (st_ff.oc_cnt >= 32'(OVERCUR_CYC)) begin
      det_code = mfs_pkg::FC_OVERCUR;
    end else if (det_timeout) begin
      det_code = mfs_pkg::FC_TIMEOUT;
    end else if (det_overload) begin
      det_code = mfs_pkg::FC_OVERLOAD;
    end else if (det_phseq) begin
      det_code = mfs_pkg::FC_PHSEQ;
    end else begin
      det_code = mfs_pkg::FC_NONE;
    end
  end

  // Auto-reset allowed except for short circuit and phase order
  assign clear_req = i_reset_key || i_din_reset
                     || (i_auto_reset && i_auto_reset_en
                         && st_ff.code != mfs_pkg::FC_SHORT
                         && st_ff.code != mfs_pkg::FC_PHSEQ);

  //----------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.sync_d   = i_sense.sync;
    nxt_st.save_vld = 1'b0;
    // Millisecond tick
    if (st_ff.tick == 32'(TICK_CYC - 1)) begin
      nxt_st.tick = 32'h0;
    end else begin
      nxt_st.tick = st_ff.tick + 32'h1;
    end
    // Thermal accumulator: heat above nominal, cool below
    if (st_ff.tick == 32'h0 && st_ff.mode != ST_INIT) begin
      if (over_nom) begin
        nxt_st.therm = (st_ff.therm == 24'hFFFFFF) ? st_ff.therm
                       : st_ff.therm + 24'h000001;
      end else if (st_ff.therm != 24'h000000) begin
        nxt_st.therm = st_ff.therm - 24'h000001;
      end
    end
    // Ramp time in ms
    if (!i_start.ramping) begin
      nxt_st.ramp_ms = 16'h0000;
    end else if (st_ff.tick == 32'h0 && st_ff.ramp_ms != 16'hFFFF) begin
      nxt_st.ramp_ms = st_ff.ramp_ms + 16'h0001;
    end
    // Overcurrent persistence
    if (det_oc_lvl) begin
      if (st_ff.oc_cnt < 32'(OVERCUR_CYC)) begin
        nxt_st.oc_cnt = st_ff.oc_cnt + 32'h1;
      end
    end else begin
      nxt_st.oc_cnt = 32'h0;
    end
    // Phase sequence position
    if (sync_fall == 3'b001) begin
      nxt_st.seq_pos = 2'd1;
    end else if (sync_fall == 3'b010) begin
      nxt_st.seq_pos = 2'd2;
    end else if (sync_fall == 3'b100) begin
      nxt_st.seq_pos = 2'd0;
    end
    // Save thermal state once on power failure
    if (i_power_fail && !st_ff.saved) begin
      nxt_st.saved    = 1'b1;
      nxt_st.save_vld = 1'b1;
    end else if (!i_power_fail) begin
      nxt_st.saved = 1'b0;
    end
    // Mode sequencing
    case (st_ff.mode)
      ST_INIT: begin
        if (i_restore_vld) begin
          nxt_st.therm = i_restore_val;
          nxt_st.mode  = ST_RUN;
        end
      end
      ST_RUN: begin
        if (det_code != mfs_pkg::FC_NONE) begin
          nxt_st.code = det_code;
          nxt_st.mode = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (clear_req) begin
          nxt_st.code   = mfs_pkg::FC_NONE;
          nxt_st.oc_cnt = 32'h0;
          nxt_st.mode   = ST_RUN;
        end
      end
      default: nxt_st.mode = ST_INIT;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_ff      <= '0;
      st_ff.mode <= ST_INIT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //----------------------------------------------------------------------
  // Indicators
  //----------------------------------------------------------------------
  logic [3:0] flash_cnt;
  logic       fault_blink;
  logic       slow_blink;

  // Fault LED flash count per code
  always_comb begin
    case (st_ff.code)
      mfs_pkg::FC_SHORT:   flash_cnt = 4'(mfs_pkg::SHORT_FLASHES);
      mfs_pkg::FC_TIMEOUT: flash_cnt = 4'(mfs_pkg::TIMEOUT_FLASHES);
      default:             flash_cnt = 4'h0;
    endcase
  end

  mfs_flasher #(
    .HALF_CYC (FLASH_CYC),
    .SLOTS    (mfs_pkg::CYCLE_SLOTS)
  ) u_fault_flash (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_count   (flash_cnt),
    .o_led     (fault_blink)
  );

  mfs_flasher #(
    .HALF_CYC (FLASH_CYC),
    .SLOTS    (mfs_pkg::CYCLE_SLOTS)
  ) u_slow_flash (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_count   (4'h9),
    .o_led     (slow_blink)
  );

  // Outputs
  assign o_fault_code    = st_ff.code;
  assign o_starter_en    = st_ff.mode == ST_RUN;
  assign o_save_vld      = st_ff.save_vld;
  assign o_save_val      = st_ff.therm;
  assign o_led.fault     = fault_blink;
  assign o_led.ready     = (st_ff.mode == ST_RUN)
                           || (st_ff.code == mfs_pkg::FC_TIMEOUT);
  assign o_led.overload  = slow_blink && st_ff.code == mfs_pkg::FC_OVERLOAD;
  assign o_led.stall     = slow_blink && st_ff.code == mfs_pkg::FC_STALL;
  assign o_led.overcur   = slow_blink && st_ff.code == mfs_pkg::FC_OVERCUR;
  assign o_led.phase_seq = slow_blink && st_ff.code == mfs_pkg::FC_PHSEQ;

endmodule

// ===== include/mfs_pkg.sv
// Notes on behaviour
// - Overload trips when thermal accumulator reaches limit
// - Thermal state saved at power-off, restored later
// - Stopped, no run: phase over 30% trips
// - Short circuit: fault LED seven flashes, ready off
// - Current-limit start only: ramp timeout trips
// - Start timeout: two fault flashes, ready on
// - Before full voltage: current over 2x trips; the code checks this only while not stopped
// - Stall shown on stall LED flashing
// - Overcurrent checked only at full voltage
// - Over 3x current beyond one second trips
// - Wrong phase interruption order trips
// - Fault disables starter; cleared by reset sources
package mfs_pkg;

  //----------------------------------------------------------------------
  // Fault codes
  //----------------------------------------------------------------------
  localparam logic [6:0] FC_NONE     = 7'h00;
  localparam logic [6:0] FC_OVERLOAD = 7'h05;
  localparam logic [6:0] FC_SHORT    = 7'h13;
  localparam logic [6:0] FC_TIMEOUT  = 7'h3E;
  localparam logic [6:0] FC_STALL    = 7'h3F;
  localparam logic [6:0] FC_OVERCUR  = 7'h42;
  localparam logic [6:0] FC_PHSEQ    = 7'h43;

  //----------------------------------------------------------------------
  // Timing and thresholds
  //----------------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int OVERCUR_MS      = 1000;
  localparam int OVERCUR_CYC     = (CLK_HZ / 1000) * OVERCUR_MS;
  localparam int TICK_MS         = 1;
  localparam int TICK_CYC        = (CLK_HZ / 1000) * TICK_MS;
  localparam int SHORT_PCT       = 30;
  localparam int STALL_MULT      = 2;
  localparam int OVERCUR_MULT    = 3;
  localparam int SHORT_FLASHES   = 7;
  localparam int TIMEOUT_FLASHES = 2;
  localparam int FLASH_HALF_MS   = 250;
  localparam int FLASH_HALF_CYC  = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int CYCLE_SLOTS     = 10;

  // Measured sensing bundle
  typedef struct packed {
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] cur_c;
    logic [2:0]  sync;
  } mfs_sense_t;

  // Start state bundle
  typedef struct packed {
    logic run_cmd;
    logic stopped;
    logic ramping;
    logic full_volt;
    logic cur_limit_mode;
  } mfs_start_t;

  // Indicator bundle
  typedef struct packed {
    logic fault;
    logic ready;
    logic overload;
    logic stall;
    logic overcur;
    logic phase_seq;
  } mfs_led_t;

endpackage

// ===== verilog/mfs_flasher.sv
`timescale 1ns/10ps
// Flash-count pattern generator: N blinks then pause per display cycle
module mfs_flasher #(
  parameter int HALF_CYC = mfs_pkg::FLASH_HALF_CYC,
  parameter int SLOTS    = mfs_pkg::CYCLE_SLOTS
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // Pattern control
  input  wire logic [3:0] i_count,
  output logic            o_led
);

  // Elaboration check: pause slot and 5-bit half counter bound the slots
  if (HALF_CYC < 1 || SLOTS < 10 || SLOTS > 16) begin : g_bad_param
    $error("mfs_flasher: bad parameters");
  end

  typedef struct packed {
    logic [31:0] tmr;
    logic [4:0]  half;
    logic        led;
  } mfs_fl_state_t;

  mfs_fl_state_t st_ff, nxt_st;

  // Half-period timer and slot counter
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.tmr == 32'(HALF_CYC - 1)) begin
      nxt_st.tmr = 32'h0;
      if (st_ff.half == 5'(2 * SLOTS - 1)) begin
        nxt_st.half = 5'h00;
      end else begin
        nxt_st.half = st_ff.half + 5'h01;
      end
    end else begin
      nxt_st.tmr = st_ff.tmr + 32'h1;
    end
    nxt_st.led = (st_ff.half[4:1] < i_count) && !st_ff.half[0];
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_led = st_ff.led;

endmodule

// ===== verification/mfs_power_model.sv
`timescale 1ns/10ps
// Power stage model: phase currents and line sync rotation
module mfs_power_model (
  // Clock and reset
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst_n,
  // Scenario control
  input  wire logic [15:0]    i_cur,
  input  wire logic           i_sync_en,
  input  wire logic           i_rev,
  // Sensed values
  output mfs_pkg::mfs_sense_t o_sense
);
  logic [3:0] step_ff;

  // Twelve steps per line period, one phase dips per group of four
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !i_sync_en || step_ff == 4'hB) begin
      step_ff <= 4'h0;
    end else begin
      step_ff <= step_ff + 4'h1;
    end
  end

  // Same current on every phase; reversed rotation dips A, C, B
  always_comb begin
    o_sense.cur_a = i_cur;
    o_sense.cur_b = i_cur;
    o_sense.cur_c = i_cur;
    o_sense.sync  = 3'h7;
    if (i_sync_en && !step_ff[1]) begin
      case (step_ff[3:2])
        2'h0:    o_sense.sync = 3'h6;
        2'h1:    o_sense.sync = i_rev ? 3'h3 : 3'h5;
        default: o_sense.sync = i_rev ? 3'h5 : 3'h3;
      endcase
    end
  end
endmodule

// ===== verification/mfs_chk.sv
`timescale 1ns/10ps
// Protocol checker for the fault supervisor
module mfs_chk #(
  parameter int OVERCUR_CYC = 20
) (
  // Clock, reset and inputs
  input wire logic                i_sys_clk,
  input wire logic                i_rst_n,
  input wire mfs_pkg::mfs_sense_t i_sense,
  input wire mfs_pkg::mfs_start_t i_start,
  input wire logic [15:0]         i_motor_nom,
  input wire logic [15:0]         i_rated,
  input wire logic                i_reset_key,
  input wire logic                i_din_reset,
  input wire logic                i_auto_reset,
  input wire logic                i_power_fail,
  // Outputs
  input wire logic                o_save_vld,
  input wire logic [6:0]          o_fault_code,
  input wire logic                o_starter_en,
  input wire mfs_pkg::mfs_led_t   o_led
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  logic        hi2;
  logic        hi3;
  logic [31:0] over_ff;

  // Current thresholds on all phases
  assign hi2 = i_sense.cur_a > 2 * i_motor_nom && i_sense.cur_b > 2 * i_motor_nom
            && i_sense.cur_c > 2 * i_motor_nom;
  assign hi3 = i_start.full_volt && i_sense.cur_a > 3 * i_motor_nom
            && i_sense.cur_b > 3 * i_motor_nom && i_sense.cur_c > 3 * i_motor_nom;

  // Run length of overcurrent while running
  always_ff @(posedge i_sys_clk) begin
    over_ff <= (!i_rst_n || !hi3 || !o_starter_en) ? 32'h0 : over_ff + 32'h1;
  end

  sequence save_pulse_s;
    o_save_vld ##1 !o_save_vld;
  endsequence

  starter_off_a: assert property (o_fault_code != 7'h00 |-> !o_starter_en)
    else $error("starter on during fault");
  code_hold_a: assert property (
    o_fault_code != 7'h00 && !i_reset_key && !i_din_reset && !i_auto_reset
    |=> $stable(o_fault_code)) else $error("fault code changed");
  short_trip_a: assert property (
    o_starter_en && i_start.stopped && !i_start.run_cmd
    && 32'(i_sense.cur_a) * 100 > 32'(i_rated) * 30 |=> o_fault_code == mfs_pkg::FC_SHORT)
    else $error("short circuit missed");
  short_ready_a: assert property (o_fault_code == mfs_pkg::FC_SHORT |-> !o_led.ready)
    else $error("ready lit on short");
  timeout_ready_a: assert property (
    o_fault_code == mfs_pkg::FC_TIMEOUT |-> o_led.ready)
    else $error("ready dark on timeout");
  stall_trip_a: assert property (
    o_starter_en && !i_start.stopped && !i_start.full_volt
    && hi2 |=> o_fault_code == mfs_pkg::FC_STALL) else $error("stall missed");
  // Lamp must light within one display cycle unless the code is cleared first
  stall_led_a: assert property (
    o_fault_code == mfs_pkg::FC_STALL
    |-> ##[0:40] (o_led.stall || o_fault_code != mfs_pkg::FC_STALL))
    else $error("stall lamp dark");
  overcur_gate_a: assert property ($changed(o_fault_code)
    && o_fault_code == mfs_pkg::FC_OVERCUR |-> $past(i_start.full_volt)
    && $past(over_ff) >= OVERCUR_CYC - 2) else $error("overcurrent too early");
  overcur_late_a: assert property (over_ff <= OVERCUR_CYC + 2)
    else $error("overcurrent trip late");
  save_pulse_a: assert property ($rose(i_power_fail) |=> save_pulse_s)
    else $error("no save pulse");
endmodule

bind mfs_supervisor mfs_chk #(.OVERCUR_CYC(OVERCUR_CYC)) u_chk (.i_sys_clk, .i_rst_n,
  .i_sense, .i_start, .i_motor_nom, .i_rated, .i_reset_key, .i_din_reset, .i_auto_reset,
  .i_power_fail, .o_save_vld, .o_fault_code, .o_starter_en, .o_led);

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam int         OC      = 20;
  localparam logic [4:0] IDLE    = 5'h08;
  localparam logic [4:0] RUNSTOP = 5'h18;
  localparam logic [4:0] RAMP    = 5'h14;
  localparam logic [4:0] RAMPCL  = 5'h15;
  localparam logic [4:0] FULL    = 5'h12;

  logic                i_sys_clk       = 1'b0;
  logic                i_rst_n         = 1'b0;
  mfs_pkg::mfs_sense_t i_sense;
  mfs_pkg::mfs_start_t i_start         = IDLE;
  logic [15:0]         i_motor_nom     = 16'h0064;
  logic [15:0]         i_rated         = 16'h0064;
  logic [15:0]         i_ramp_ms       = 16'h0004;
  logic [23:0]         i_therm_limit   = 24'hFFFFFF;
  logic                i_auto_reset_en = 1'b0;
  logic                i_reset_key     = 1'b0;
  logic                i_din_reset     = 1'b0;
  logic                i_auto_reset    = 1'b0;
  logic                i_power_fail    = 1'b0;
  logic                i_restore_vld   = 1'b0;
  logic [23:0]         i_restore_val   = 24'h0;
  logic                o_save_vld;
  logic [23:0]         o_save_val;
  logic [6:0]          o_fault_code;
  logic                o_starter_en;
  mfs_pkg::mfs_led_t   o_led;
  logic [15:0]         cur             = 16'h0;
  logic                sen             = 1'b0;
  logic                rev             = 1'b0;
  int                  err_count       = 0;
  int                  checks_done     = 0;
  int                  cyc             = 0;

  mfs_power_model u_pwr (.i_sys_clk, .i_rst_n, .i_cur(cur), .i_sync_en(sen), .i_rev(rev),
    .o_sense(i_sense));
  mfs_supervisor #(.OVERCUR_CYC(OC), .TICK_CYC(4), .FLASH_CYC(2)) dut (.i_sys_clk, .i_rst_n,
    .i_sense, .i_start, .i_motor_nom, .i_rated, .i_ramp_ms, .i_therm_limit, .i_auto_reset_en,
    .i_reset_key, .i_din_reset, .i_auto_reset, .i_power_fail, .i_restore_vld, .i_restore_val,
    .o_save_vld, .o_save_val, .o_fault_code, .o_starter_en, .o_led);

  // Clock and hang guard
  always #20 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic wait_code(input logic [6:0] exp, input int n);
    for (int i = 0; i < n && o_fault_code !== exp; i++) @(negedge i_sys_clk);
    check("fault code", 24'(o_fault_code), 24'(exp));
  endtask

  // One clear request, then the code must be gone
  task automatic pulse(ref logic s);
    s = 1'b1;
    cycles(1);
    s = 1'b0;
    cycles(2);
    check("cleared code", 24'(o_fault_code), 24'h0);
  endtask

  // Indicator bit of o_led must light at least once over one display cycle
  task automatic lamp(input string nm, input int b);
    logic [23:0] n;
    n = 24'h0;
    repeat (40) begin
      @(negedge i_sys_clk);
      if (o_led[b]) n = 24'h1;
    end
    check(nm, n, 24'h1);
  endtask

  // Rising edges of the fault lamp over one display cycle
  task automatic blinks(input logic [23:0] exp);
    logic [23:0] n;
    logic        prev;
    n = 24'h0;
    // Let the lamp register follow the new code before sampling
    @(negedge i_sys_clk);
    prev = o_led.fault;
    repeat (40) begin
      @(negedge i_sys_clk);
      if (o_led.fault && !prev) n = n + 24'h1;
      prev = o_led.fault;
    end
    check("fault flashes", n, exp);
  endtask

  task automatic boot(input logic [23:0] val);
    i_rst_n = 1'b0;
    cycles(5);
    i_rst_n = 1'b1;
    cycles(2);
    check("starter before restore", 24'(o_starter_en), 24'h0);
    i_restore_val = val;
    i_restore_vld = 1'b1;
    cycles(1);
    i_restore_vld = 1'b0;
    check("starter after restore", 24'(o_starter_en), 24'h1);
  endtask

  initial begin
    @(negedge i_sys_clk);
    boot(24'h0);
    // Short circuit at the threshold and just above
    cur = 16'h001E;
    cycles(4);
    check("code at threshold", 24'(o_fault_code), 24'h0);
    cur = 16'h001F;
    wait_code(mfs_pkg::FC_SHORT, 4);
    check("ready lamp", 24'(o_led.ready), 24'h0);
    blinks(24'h7);
    i_auto_reset_en = 1'b1;
    i_auto_reset = 1'b1;
    cycles(2);
    i_auto_reset = 1'b0;
    check("code after auto", 24'(o_fault_code), 24'(mfs_pkg::FC_SHORT));
    cur = 16'h0;
    pulse(i_reset_key);
    $display("short circuit test done");
    // Ramp timeout only in current limit mode
    i_start = RAMP;
    cycles(30);
    check("plain ramp code", 24'(o_fault_code), 24'h0);
    i_start = IDLE;
    cycles(2);
    i_start = RAMPCL;
    cycles(8);
    check("early ramp code", 24'(o_fault_code), 24'h0);
    wait_code(mfs_pkg::FC_TIMEOUT, 16);
    check("ready lamp", 24'(o_led.ready), 24'h1);
    blinks(24'h2);
    i_start = IDLE;
    pulse(i_din_reset);
    $display("timeout test done");
    // Stall at twice nominal and just above
    i_start = RAMP;
    cur = 16'h00C8;
    cycles(4);
    check("stall at limit", 24'(o_fault_code), 24'h0);
    cur = 16'h00C9;
    wait_code(mfs_pkg::FC_STALL, 4);
    lamp("stall lamp", 2);
    i_start = IDLE;
    cur = 16'h0;
    pulse(i_auto_reset);
    $display("stall test done");
    // Overcurrent ignored while stopped, timed at full voltage
    i_start = RUNSTOP;
    cur = 16'h012D;
    cycles(30);
    check("overcurrent stopped", 24'(o_fault_code), 24'h0);
    i_start = FULL;
    cycles(OC - 4);
    check("overcurrent early", 24'(o_fault_code), 24'h0);
    wait_code(mfs_pkg::FC_OVERCUR, 8);
    lamp("overcurrent lamp", 1);
    i_start = IDLE;
    cycles(3);
    check("first code kept", 24'(o_fault_code), 24'(mfs_pkg::FC_OVERCUR));
    cur = 16'h0;
    pulse(i_reset_key);
    $display("overcurrent test done");
    // Overload, thermal save and restore across a reset
    i_therm_limit = 24'h5;
    i_start = FULL;
    cur = 16'h0096;
    boot(24'h0);
    cycles(12);
    check("overload early", 24'(o_fault_code), 24'h0);
    wait_code(mfs_pkg::FC_OVERLOAD, 40);
    i_power_fail = 1'b1;
    cycles(1);
    check("save strobe", 24'(o_save_vld), 24'h1);
    check("saved state", 24'(o_save_val >= 24'h5), 24'h1);
    i_power_fail = 1'b0;
    boot(24'h4);
    wait_code(mfs_pkg::FC_OVERLOAD, 10);
    lamp("overload lamp", 3);
    i_therm_limit = 24'hFFFFFF;
    i_start = IDLE;
    cur = 16'h0;
    pulse(i_reset_key);
    $display("overload test done");
    // Phase rotation, right then reversed
    sen = 1'b1;
    cycles(48);
    check("right rotation", 24'(o_fault_code), 24'h0);
    rev = 1'b1;
    wait_code(mfs_pkg::FC_PHSEQ, 24);
    lamp("phase order lamp", 0);
    $display("phase order test done");
    finish_test();
  end
endmodule
